// ---- hdl/moc_top.sv ----
`timescale 1ns/1ps
`include "moc_consts.svh"
module moc_top import moc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire moc_wb_req_type wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Process side
  input wire logic signed [15:0] measured_value_i,
  input wire logic signed [15:0] target_setpoint_i,
  input wire logic signed [15:0] input_span_i,
  input wire logic signed [15:0] pid_heat_i,
  input wire logic signed [15:0] pid_cool_i,
  input wire moc_mode_type mode_i,
  input wire logic err_hi_i,
  input wire logic err_lo_i,
  input wire logic ctl_tick_i,
  // Actuator side
  output logic signed [15:0] heat_side_output_o,
  output logic signed [15:0] cool_side_output_o,
  output logic force_manual_o,
  output logic valve_stop_action_o,
  output logic onoff_state_o
);

  logic signed [15:0] pband;
  logic signed [15:0] gap_up;
  logic signed [15:0] gap_lo;
  logic signed [15:0] err_mv;
  logic signed [15:0] stop_heat;
  logic signed [15:0] stop_cool;
  logic [15:0] rup_heat;
  logic [15:0] rdn_heat;
  logic [15:0] rup_cool;
  logic [15:0] rdn_cool;
  logic signed [15:0] limh_heat;
  logic signed [15:0] liml_heat;
  logic signed [15:0] limh_cool;
  logic signed [15:0] liml_cool;
  logic act_hi;
  logic act_lo;
  logic subst;
  logic onoff_on;
  logic err_hi_prev;
  logic err_lo_prev;
  logic signed [23:0] acc_heat;
  logic signed [23:0] acc_cool;
  logic signed [15:0] tgt_heat;
  logic signed [15:0] tgt_cool;
  logic hold_heat;

  function automatic logic signed [15:0] sat(input logic signed [16:0] v,
                                             input logic signed [15:0] lo,
                                             input logic signed [15:0] hi);
    begin
      if (v < 17'(lo)) begin
        sat = lo;
      end else if (v > 17'(hi)) begin
        sat = hi;
      end else begin
        sat = v[15:0];
      end
    end
  endfunction : sat

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    begin
      merge = old;
      if (s[0]) begin
        merge[7:0] = d[7:0];
      end
      if (s[1]) begin
        merge[15:8] = d[15:8];
      end
    end
  endfunction : merge

  function automatic logic signed [23:0] rate_step(input logic signed [23:0] cur,
                                                   input logic signed [23:0] tgt,
                                                   input logic [15:0] up,
                                                   input logic [15:0] dn,
                                                   input logic bypass);
    logic signed [23:0] up_s;
    logic signed [23:0] dn_s;
    logic signed [23:0] d;
    begin
      up_s = $signed({8'h00, up}) * `MOC_RATE_STEP;
      dn_s = $signed({8'h00, dn}) * `MOC_RATE_STEP;
      d = tgt - cur;
      rate_step = tgt;
      if (!bypass && up != 16'h0000 && d > up_s) begin
        rate_step = cur + up_s;
      end
      if (!bypass && dn != 16'h0000 && d < -dn_s) begin
        rate_step = cur - dn_s;
      end
    end
  endfunction : rate_step

  // Bus decode
  wire wb_req = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  wire wb_wr = wb_req & wb_i.we;
  wire [7:0] adr = wb_i.adr;
  wire signed [15:0] pband_w = $signed(merge(pband, wb_i.dat, wb_i.sel));
  // gap span depends on input type
  wire signed [15:0] gap_max = mode_i.analog_in ? `MOC_PCT_FULL : input_span_i;
  wire [15:0] gap_up_m = merge(gap_up, wb_i.dat, wb_i.sel);
  wire [15:0] gap_lo_m = merge(gap_lo, wb_i.dat, wb_i.sel);
  wire signed [15:0] gap_up_w = sat(17'($signed(gap_up_m)), `MOC_PCT_ZERO, gap_max);
  wire signed [15:0] gap_lo_w = sat(17'($signed(gap_lo_m)), `MOC_PCT_ZERO, gap_max);
  wire [15:0] err_mv_m = merge(err_mv, wb_i.dat, wb_i.sel);
  wire signed [15:0] err_mv_w = sat(17'($signed(err_mv_m)), `MOC_ERR_MIN, `MOC_ERR_MAX);
  wire [15:0] stop_h_m = merge(stop_heat, wb_i.dat, wb_i.sel);
  wire [15:0] stop_c_m = merge(stop_cool, wb_i.dat, wb_i.sel);
  wire [15:0] lim_m = merge(16'h0000, wb_i.dat, wb_i.sel);
  wire signed [15:0] stop_h_w = sat(17'($signed(stop_h_m)), `MOC_STOP_MIN, `MOC_STOP_MAX);
  wire signed [15:0] stop_c_w = sat(17'($signed(stop_c_m)), `MOC_STOP_MIN, `MOC_STOP_MAX);
  wire signed [15:0] lim_w = sat(17'($signed(lim_m)), `MOC_STOP_MIN, `MOC_STOP_MAX);
  wire [15:0] rup_h_m = merge(rup_heat, wb_i.dat, wb_i.sel);
  wire [15:0] rdn_h_m = merge(rdn_heat, wb_i.dat, wb_i.sel);
  wire [15:0] rup_c_m = merge(rup_cool, wb_i.dat, wb_i.sel);
  wire [15:0] rdn_c_m = merge(rdn_cool, wb_i.dat, wb_i.sel);
  wire [15:0] rup_h_w = rup_h_m > `MOC_RATE_MAX ? `MOC_RATE_MAX : rup_h_m;
  wire [15:0] rdn_h_w = rdn_h_m > `MOC_RATE_MAX ? `MOC_RATE_MAX : rdn_h_m;
  wire [15:0] rup_c_w = rup_c_m > `MOC_RATE_MAX ? `MOC_RATE_MAX : rup_c_m;
  wire [15:0] rdn_c_w = rdn_c_m > `MOC_RATE_MAX ? `MOC_RATE_MAX : rdn_c_m;

  // Control conditions
  // band of zero means ON/OFF
  wire onoff_mode = (pband == `MOC_PCT_ZERO);
  wire fb_ok = ~mode_i.pos_prop | (mode_i.fb_present & ~mode_i.fb_broken);
  wire signed [16:0] on_thr = 17'(target_setpoint_i) - 17'(gap_lo);
  wire signed [16:0] off_thr = 17'(target_setpoint_i) + 17'(gap_up);
  // only an edge while running counts, so an error carried over from stop never triggers
  wire err_rise = (err_hi_i & ~err_hi_prev & act_hi) | (err_lo_i & ~err_lo_prev & act_lo);
  wire subst_set = err_rise & mode_i.run & mode_i.auto_mode;
  // Substitution leaves with stop or a write of one to its status bit; a new trigger wins
  wire subst_clr = ~mode_i.run | (wb_wr & adr == `MOC_REG_STATUS & wb_i.sel[0] & wb_i.dat[`MOC_ST_SUBST]);
  wire next_subst = subst_set | (subst & ~subst_clr);
  wire rate_bypass = mode_i.pos_prop;
  wire signed [23:0] tgt_heat_s = $signed({{8{tgt_heat[15]}}, tgt_heat}) * `MOC_SCALE;
  wire signed [23:0] tgt_cool_s = $signed({{8{tgt_cool[15]}}, tgt_cool}) * `MOC_SCALE;
  wire signed [23:0] next_acc_heat = hold_heat ? acc_heat :
                                     rate_step(acc_heat, tgt_heat_s, rup_heat, rdn_heat, rate_bypass);
  wire signed [23:0] next_acc_cool = rate_step(acc_cool, tgt_cool_s, rup_cool, rdn_cool, rate_bypass);
  wire signed [23:0] q_heat = next_acc_heat / `MOC_SCALE;
  wire signed [23:0] q_cool = next_acc_cool / `MOC_SCALE;

  // Output targets
  always_comb begin
    tgt_heat = pid_heat_i;
    tgt_cool = pid_cool_i;
    hold_heat = 1'b0;
    if (!mode_i.run) begin
      tgt_heat = stop_heat;
      tgt_cool = stop_cool;
      // heat preset only with good feedback
      hold_heat = ~fb_ok;
    end else if (subst) begin
      tgt_heat = sat(17'(err_mv), liml_heat, limh_heat);
      tgt_cool = sat(17'(`MOC_PCT_ZERO), liml_cool, limh_cool);
      // positioner without feedback follows stop valve action
      hold_heat = ~fb_ok;
    end else if (onoff_mode) begin
      tgt_heat = sat(17'(onoff_on ? `MOC_PCT_FULL : `MOC_PCT_ZERO), liml_heat, limh_heat);
      tgt_cool = sat(17'(`MOC_PCT_ZERO), liml_cool, limh_cool);
    end else begin
      tgt_heat = sat(17'(pid_heat_i), liml_heat, limh_heat);
      tgt_cool = sat(17'(pid_cool_i), liml_cool, limh_cool);
    end
  end

  // Write strobes, one per register word
  wire wr_ctrl = wb_wr & (adr == `MOC_REG_CTRL) & wb_i.sel[0];
  wire wr_pband = wb_wr & (adr == `MOC_REG_PBAND);
  wire wr_gap_up = wb_wr & (adr == `MOC_REG_GAP_UP);
  wire wr_gap_lo = wb_wr & (adr == `MOC_REG_GAP_LO);
  wire wr_err_mv = wb_wr & (adr == `MOC_REG_ERR_MV);
  wire wr_stop_heat = wb_wr & (adr == `MOC_REG_STOP_HEAT);
  wire wr_stop_cool = wb_wr & (adr == `MOC_REG_STOP_COOL);
  wire wr_rup_heat = wb_wr & (adr == `MOC_REG_RUP_HEAT);
  wire wr_rdn_heat = wb_wr & (adr == `MOC_REG_RDN_HEAT);
  wire wr_rup_cool = wb_wr & (adr == `MOC_REG_RUP_COOL);
  wire wr_rdn_cool = wb_wr & (adr == `MOC_REG_RDN_COOL);
  // A limit moves only on a full 16-bit write, so a half word never lands alone
  wire wr_lim = wb_wr & (wb_i.sel[1:0] == 2'h3);
  wire wr_limh_heat = wr_lim & (adr == `MOC_REG_LIMH_HEAT);
  wire wr_liml_heat = wr_lim & (adr == `MOC_REG_LIML_HEAT);
  wire wr_limh_cool = wr_lim & (adr == `MOC_REG_LIMH_COOL);
  wire wr_liml_cool = wr_lim & (adr == `MOC_REG_LIML_COOL);

  // Error action selectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // both selectors default to normal control
      act_hi <= 1'b0;
      act_lo <= 1'b0;
    end else if (wr_ctrl) begin
      act_hi <= wb_i.dat[`MOC_CTRL_ACT_HI];
      act_lo <= wb_i.dat[`MOC_CTRL_ACT_LO];
    end
  end

  // Band, gaps, error value and stop presets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pband <= `MOC_RST_PBAND;
      gap_up <= `MOC_RST_GAP;
      gap_lo <= `MOC_RST_GAP;
      err_mv <= `MOC_RST_ERR_MV;
      stop_heat <= `MOC_RST_STOP;
      stop_cool <= `MOC_RST_STOP;
    end else begin
      pband <= wr_pband ? pband_w : pband;
      gap_up <= wr_gap_up ? gap_up_w : gap_up;
      gap_lo <= wr_gap_lo ? gap_lo_w : gap_lo;
      err_mv <= wr_err_mv ? err_mv_w : err_mv;
      stop_heat <= wr_stop_heat ? stop_h_w : stop_heat;
      stop_cool <= wr_stop_cool ? stop_c_w : stop_cool;
    end
  end

  // Change-rate limits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rup_heat <= `MOC_RST_RATE;
      rdn_heat <= `MOC_RST_RATE;
      rup_cool <= `MOC_RST_RATE;
      rdn_cool <= `MOC_RST_RATE;
    end else begin
      rup_heat <= wr_rup_heat ? rup_h_w : rup_heat;
      rdn_heat <= wr_rdn_heat ? rdn_h_w : rdn_heat;
      rup_cool <= wr_rup_cool ? rup_c_w : rup_cool;
      rdn_cool <= wr_rdn_cool ? rdn_c_w : rdn_cool;
    end
  end

  // Output limits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limh_heat <= `MOC_RST_LIMH;
      liml_heat <= `MOC_RST_LIML;
      limh_cool <= `MOC_RST_LIMH;
      liml_cool <= `MOC_RST_LIML;
    end else begin
      limh_heat <= wr_limh_heat ? lim_w : limh_heat;
      liml_heat <= wr_liml_heat ? lim_w : liml_heat;
      limh_cool <= wr_limh_cool ? lim_w : limh_cool;
      liml_cool <= wr_liml_cool ? lim_w : liml_cool;
    end
  end

  // Read mux; unmapped words read zero
  wire [31:0] status_word = {28'h0000000, fb_ok, subst, onoff_on, onoff_mode};
  logic [31:0] rd_data;
  always_comb begin
    unique case (adr)
      `MOC_REG_CTRL: rd_data = {30'h00000000, act_lo, act_hi};
      `MOC_REG_PBAND: rd_data = {16'h0000, pband};
      `MOC_REG_GAP_UP: rd_data = {16'h0000, gap_up};
      `MOC_REG_GAP_LO: rd_data = {16'h0000, gap_lo};
      `MOC_REG_ERR_MV: rd_data = {16'h0000, err_mv};
      `MOC_REG_STOP_HEAT: rd_data = {16'h0000, stop_heat};
      `MOC_REG_STOP_COOL: rd_data = {16'h0000, stop_cool};
      `MOC_REG_RUP_HEAT: rd_data = {16'h0000, rup_heat};
      `MOC_REG_RDN_HEAT: rd_data = {16'h0000, rdn_heat};
      `MOC_REG_RUP_COOL: rd_data = {16'h0000, rup_cool};
      `MOC_REG_RDN_COOL: rd_data = {16'h0000, rdn_cool};
      `MOC_REG_LIMH_HEAT: rd_data = {16'h0000, limh_heat};
      `MOC_REG_LIML_HEAT: rd_data = {16'h0000, liml_heat};
      `MOC_REG_LIMH_COOL: rd_data = {16'h0000, limh_cool};
      `MOC_REG_LIML_COOL: rd_data = {16'h0000, liml_cool};
      `MOC_REG_STATUS: rd_data = status_word;
      `MOC_REG_OUTS: rd_data = {cool_side_output_o, heat_side_output_o};
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : wb_dat_o;
    end
  end

  // Error tracking and ON/OFF state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_hi_prev <= 1'b0;
      err_lo_prev <= 1'b0;
      subst <= 1'b0;
      onoff_on <= 1'b0;
    end else begin
      err_hi_prev <= err_hi_i;
      err_lo_prev <= err_lo_i;
      subst <= next_subst;
      // hold state between the two gaps
      // switch points at setpoint minus lower, plus upper
      if (17'(measured_value_i) < on_thr || (gap_lo == `MOC_PCT_ZERO && measured_value_i < target_setpoint_i)) begin
        onoff_on <= 1'b1;
      end else if (17'(measured_value_i) > off_thr) begin
        onoff_on <= 1'b0;
      end
    end
  end

  // Output stage; the fine accumulator keeps slow rates from rounding to no motion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_heat <= 24'sh000000;
      acc_cool <= 24'sh000000;
      heat_side_output_o <= `MOC_PCT_ZERO;
      cool_side_output_o <= `MOC_PCT_ZERO;
      force_manual_o <= 1'b0;
      valve_stop_action_o <= 1'b0;
      onoff_state_o <= 1'b0;
    end else begin
      force_manual_o <= next_subst;
      valve_stop_action_o <= hold_heat;
      onoff_state_o <= onoff_on;
      // one rate step per control tick
      if (ctl_tick_i) begin
        acc_heat <= next_acc_heat;
        acc_cool <= next_acc_cool;
        heat_side_output_o <= q_heat[15:0];
        cool_side_output_o <= q_cool[15:0];
      end
    end
  end

endmodule : moc_top

// ---- hdl/moc_consts.svh ----
`ifndef MOC_CONSTS_SVH
`define MOC_CONSTS_SVH
// Register byte offsets (one 32-bit word each)
`define MOC_REG_CTRL 8'h00
`define MOC_REG_PBAND 8'h04
`define MOC_REG_GAP_UP 8'h08
`define MOC_REG_GAP_LO 8'h0c
`define MOC_REG_ERR_MV 8'h10
`define MOC_REG_STOP_HEAT 8'h14
`define MOC_REG_STOP_COOL 8'h18
`define MOC_REG_RUP_HEAT 8'h1c
`define MOC_REG_RDN_HEAT 8'h20
`define MOC_REG_RUP_COOL 8'h24
`define MOC_REG_RDN_COOL 8'h28
`define MOC_REG_LIMH_HEAT 8'h2c
`define MOC_REG_LIML_HEAT 8'h30
`define MOC_REG_LIMH_COOL 8'h34
`define MOC_REG_LIML_COOL 8'h38
`define MOC_REG_STATUS 8'h3c
`define MOC_REG_OUTS 8'h40
// Control register fields
`define MOC_CTRL_ACT_HI 0
`define MOC_CTRL_ACT_LO 1
// Status register fields
`define MOC_ST_ONOFF_MODE 0
`define MOC_ST_ONOFF_ON 1
`define MOC_ST_SUBST 2
`define MOC_ST_FB_OK 3
// Value ranges, 0.1 % units
`define MOC_PCT_FULL 16'sh03e8
`define MOC_PCT_ZERO 16'sh0000
`define MOC_ERR_MIN 16'shfbe6
`define MOC_ERR_MAX 16'sh041a
`define MOC_STOP_MIN 16'shffce
`define MOC_STOP_MAX 16'sh041a
`define MOC_RATE_MAX 16'h03e8
// Reset values
`define MOC_RST_GAP 16'sh0001
`define MOC_RST_ERR_MV 16'sh0000
`define MOC_RST_STOP 16'shffce
`define MOC_RST_RATE 16'h0000
`define MOC_RST_LIMH 16'sh041a
`define MOC_RST_LIML 16'shffce
`define MOC_RST_PBAND 16'sh0000
// Control cycle timing; the accumulator runs 1000x finer than the outputs
`define MOC_CYCLE_MS 24'sd100
`define MOC_MS_PER_S 24'sd1000
`define MOC_SCALE 24'sd1000
`define MOC_RATE_STEP (`MOC_SCALE * `MOC_CYCLE_MS / `MOC_MS_PER_S)
`endif

// ---- hdl/moc_pkg.sv ----
package moc_pkg;
  typedef struct packed {
    logic run;
    logic auto_mode;
    logic pos_prop;
    logic fb_present;
    logic fb_broken;
    logic analog_in;
  } moc_mode_type;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } moc_wb_req_type;
endpackage : moc_pkg

// ---- verification/moc_top_properties.sv ----
`timescale 1ns/1ps
module moc_top_checker import moc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire moc_wb_req_type wb_i,
  input wire logic wb_ack_o,
  // Process side
  input wire logic signed [15:0] measured_value_i,
  input wire logic signed [15:0] target_setpoint_i,
  input wire moc_mode_type mode_i,
  input wire logic err_hi_i,
  input wire logic err_lo_i,
  input wire logic ctl_tick_i,
  // Actuator side
  input wire logic signed [15:0] heat_side_output_o,
  input wire logic signed [15:0] cool_side_output_o,
  input wire logic force_manual_o,
  input wire logic onoff_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next_cycle: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  a_outputs_hold_tick: assert property (!ctl_tick_i |=> $stable(heat_side_output_o) && $stable(cool_side_output_o))
    else $error("output moved without tick");
  a_subst_auto_run: assert property ($rose(force_manual_o) |-> $past(mode_i.auto_mode) && $past(mode_i.run))
    else $error("substitution outside auto run");
  a_subst_error_edge: assert property ($rose(force_manual_o) |->
    ($past(err_hi_i) && !$past(err_hi_i, 2)) || ($past(err_lo_i) && !$past(err_lo_i, 2)))
    else $error("substitution without fresh error");
  a_stop_clears_subst: assert property (!mode_i.run |=> !force_manual_o)
    else $error("substitution held in stop");
  a_onoff_on_below: assert property ($rose(onoff_state_o) |-> $past(measured_value_i < target_setpoint_i, 2))
    else $error("on state without low value");
  a_onoff_off_above: assert property ($fell(onoff_state_o) && $past(mode_i.run) |->
    $past(measured_value_i > target_setpoint_i, 2))
    else $error("off state without high value");
  a_heat_range: assert property (heat_side_output_o >= -16'sh0032 && heat_side_output_o <= 16'sh041a)
    else $error("heat output out of range");
  a_cool_range: assert property (cool_side_output_o >= -16'sh0032 && cool_side_output_o <= 16'sh041a)
    else $error("cool output out of range");
endmodule : moc_top_checker

bind moc_top moc_top_checker u_moc_top_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
  .measured_value_i(measured_value_i), .target_setpoint_i(target_setpoint_i), .mode_i(mode_i),
  .err_hi_i(err_hi_i), .err_lo_i(err_lo_i), .ctl_tick_i(ctl_tick_i), .heat_side_output_o(heat_side_output_o),
  .cool_side_output_o(cool_side_output_o), .force_manual_o(force_manual_o), .onoff_state_o(onoff_state_o));

// ---- verification/moc_actuator.sv ----
`timescale 1ns/1ps
module moc_actuator (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive from controller
  input wire logic signed [15:0] heat_i,
  input wire logic signed [15:0] cool_i,
  input wire logic valve_stop_i,
  // Applied drive
  output logic signed [15:0] heat_o,
  output logic signed [15:0] cool_o
);
  // The heat valve keeps its last position while the hold is asked; the cool drive always follows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      heat_o <= 16'sh0000;
      cool_o <= 16'sh0000;
    end else begin
      if (!valve_stop_i) begin
        heat_o <= heat_i;
      end
      cool_o <= cool_i;
    end
  end
endmodule : moc_actuator

// ---- verification/tb_moc_top.sv ----
`timescale 1ns/1ps
`include "moc_consts.svh"
module tb_moc_top;
  import moc_pkg::*;
  logic clk_i, rst_i, ctl_tick_i, err_hi_i, err_lo_i, wb_ack_o, force_manual_o, valve_stop_action_o, onoff_state_o;
  moc_wb_req_type wb_i;
  moc_mode_type mode_i;
  logic signed [15:0] pv, sv, pid_h, pid_c, heat, cool, act_heat, act_cool, span;
  logic [31:0] wb_dat_o, q;
  int miscompares, compares;
  logic [7:0] adr_tab [15] = '{`MOC_REG_GAP_UP, `MOC_REG_GAP_LO, `MOC_REG_ERR_MV, `MOC_REG_STOP_HEAT,
    `MOC_REG_STOP_COOL, `MOC_REG_RUP_HEAT, `MOC_REG_RDN_HEAT, `MOC_REG_RUP_COOL, `MOC_REG_RDN_COOL,
    `MOC_REG_LIMH_HEAT, `MOC_REG_LIML_HEAT, `MOC_REG_LIMH_COOL, `MOC_REG_LIML_COOL, `MOC_REG_PBAND, 8'h44};
  logic [15:0] exp_tab [15] = '{16'h0001, 16'h0001, 16'h0000, 16'hffce, 16'hffce, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h041a, 16'hffce, 16'h041a, 16'hffce, 16'h0000, 16'h0000};
  moc_top u_moc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .measured_value_i(pv), .target_setpoint_i(sv), .input_span_i(span), .pid_heat_i(pid_h),
    .pid_cool_i(pid_c), .mode_i(mode_i), .err_hi_i(err_hi_i), .err_lo_i(err_lo_i), .ctl_tick_i(ctl_tick_i),
    .heat_side_output_o(heat), .cool_side_output_o(cool), .force_manual_o(force_manual_o),
    .valve_stop_action_o(valve_stop_action_o), .onoff_state_o(onoff_state_o));
  moc_actuator u_moc_actuator (.clk_i(clk_i), .rst_i(rst_i), .heat_i(heat), .cool_i(cool),
    .valve_stop_i(valve_stop_action_o), .heat_o(act_heat), .cool_o(act_cool));
  task end_of_test;
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task xfer(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{adr: a, dat: d, sel: s, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    q = wb_dat_o;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [15:0] d);
    xfer(a, 1'b1, 4'hf, {16'h0000, d});
  endtask : wr
  task rd(input string n, input logic [7:0] a, input logic [15:0] e);
    xfer(a, 1'b0, 4'hf, 32'h0);
    chk(n, {16'h0000, e}, q);
  endtask : rd
  task tick(input logic [15:0] eh, input logic [15:0] ec);
    @(posedge clk_i) ctl_tick_i <= 1'b1;
    @(posedge clk_i) ctl_tick_i <= 1'b0;
    @(negedge clk_i);
    chk("heat", {16'h0000, eh}, {16'h0000, heat});
    chk("cool", {16'h0000, ec}, {16'h0000, cool});
  endtask : tick
  task err_step(input logic hi, input logic lo, input logic e);
    @(posedge clk_i) err_hi_i <= hi;
    err_lo_i <= lo;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) chk("force_manual", {31'h0, e}, {31'h0, force_manual_o});
    @(posedge clk_i) err_hi_i <= 1'b0;
    err_lo_i <= 1'b0;
  endtask : err_step
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    mode_i = '{run: 1'b0, auto_mode: 1'b1, pos_prop: 1'b0, fb_present: 1'b1, fb_broken: 1'b0, analog_in: 1'b0};
    {ctl_tick_i, err_hi_i, err_lo_i} = 3'h0;
    {pv, sv, pid_h, pid_c} = {16'sh0032, 16'sh0064, 16'sh0000, 16'sh0000};
    span = 16'sh0200;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 15; i++) rd("reset_value", adr_tab[i], exp_tab[i]);
    tick(`MOC_RST_STOP, `MOC_RST_STOP);
    wr(`MOC_REG_STOP_COOL, 16'h07d0);
    wr(`MOC_REG_STOP_HEAT, 16'hff9c);
    rd("stop_cool", `MOC_REG_STOP_COOL, 16'h041a);
    tick(`MOC_STOP_MIN, `MOC_STOP_MAX);
    @(posedge clk_i) mode_i.run <= 1'b1;
    tick(`MOC_PCT_FULL, 16'h0000);
    rd("onoff_status", `MOC_REG_STATUS, 16'h000b);
    chk("onoff_state", 32'h1, {31'h0, onoff_state_o});
    @(posedge clk_i) pv <= 16'sh0065;
    tick(`MOC_PCT_FULL, 16'h0000);
    @(posedge clk_i) pv <= 16'sh0066;
    tick(16'h0000, 16'h0000);
    @(posedge clk_i) pv <= 16'sh0063;
    tick(16'h0000, 16'h0000);
    @(posedge clk_i) pv <= 16'sh0062;
    tick(`MOC_PCT_FULL, 16'h0000);
    wr(`MOC_REG_GAP_UP, 16'h07d0);
    rd("gap_span", `MOC_REG_GAP_UP, 16'h0200);
    @(posedge clk_i) mode_i.analog_in <= 1'b1;
    wr(`MOC_REG_GAP_LO, 16'h07d0);
    rd("gap_pct", `MOC_REG_GAP_LO, 16'h03e8);
    wr(`MOC_REG_PBAND, 16'h000a);
    @(posedge clk_i) pv <= 16'sh00c8;
    tick(16'h0000, 16'h0000);
    wr(`MOC_REG_RUP_HEAT, 16'h0064);
    wr(`MOC_REG_RDN_HEAT, 16'h0032);
    wr(`MOC_REG_RUP_COOL, 16'h0032);
    @(posedge clk_i) {pid_h, pid_c} <= {`MOC_PCT_FULL, `MOC_PCT_FULL};
    tick(16'h000a, 16'h0005);
    tick(16'h0014, 16'h000a);
    @(posedge clk_i) {pid_h, pid_c} <= 32'h0;
    tick(16'h000f, 16'h0000);
    wr(`MOC_REG_RUP_HEAT, 16'h07d0);
    rd("rate_up", `MOC_REG_RUP_HEAT, `MOC_RATE_MAX);
    @(posedge clk_i) mode_i.pos_prop <= 1'b1;
    pid_h <= `MOC_PCT_FULL;
    tick(`MOC_PCT_FULL, 16'h0000);
    @(posedge clk_i) mode_i.pos_prop <= 1'b0;
    wr(`MOC_REG_RDN_HEAT, 16'h0000);
    wr(`MOC_REG_CTRL, 16'h0001);
    wr(`MOC_REG_ERR_MV, 16'h07d0);
    rd("err_mv", `MOC_REG_ERR_MV, 16'h041a);
    xfer(`MOC_REG_LIMH_HEAT, 1'b1, 4'h1, 32'h0320);
    rd("lim_part_write", `MOC_REG_LIMH_HEAT, 16'h041a);
    wr(`MOC_REG_LIMH_HEAT, 16'h0320);
    err_step(1'b1, 1'b0, 1'b1);
    tick(16'h0320, 16'h0000);
    wr(`MOC_REG_STATUS, 16'h0004);
    wr(`MOC_REG_CTRL, 16'h0002);
    err_step(1'b1, 1'b0, 1'b0);
    err_step(1'b0, 1'b1, 1'b1);
    wr(`MOC_REG_STATUS, 16'h0004);
    wr(`MOC_REG_CTRL, 16'h0003);
    @(posedge clk_i) mode_i.auto_mode <= 1'b0;
    err_step(1'b1, 1'b0, 1'b0);
    @(posedge clk_i) {mode_i.run, mode_i.auto_mode, err_hi_i} <= 3'b011;
    repeat (3) @(posedge clk_i);
    mode_i.run <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) chk("force_at_run", 32'h0, {31'h0, force_manual_o});
    @(posedge clk_i) {mode_i.run, mode_i.pos_prop, mode_i.fb_present, err_hi_i} <= 4'b0100;
    tick(16'h0320, `MOC_STOP_MAX);
    chk("valve_stop", 32'h1, {31'h0, valve_stop_action_o});
    chk("applied_heat", 32'h0320, {16'h0, act_heat});
    end_of_test();
  end
endmodule : tb_moc_top
